// [rtl/rasm_reset_monitor.sv]
// reset sequencer, supply monitor filter and reset-state core registers
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module rasm_reset_monitor #(
    parameter int MON_CYC = rasm_pkg::MON_FILTER_CYC,
    parameter int STAB_CYC = rasm_pkg::STAB_MIN_FX
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rasm_pkg::APB_AW-1:0] paddr,
    input wire logic [rasm_pkg::APB_DW-1:0] pwdata,
    output logic [rasm_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset pin, open drain
    input wire logic resetPinIn,
    output logic resetPinOut,
    output logic resetPinOe,
    // supply comparator and key pins
    input wire logic supplyLow,
    input wire logic [rasm_pkg::KEY_W-1:0] keyInputPins,
    // core events
    input wire logic standbyActive,
    input wire logic haltExec,
    input wire logic [rasm_pkg::HALT_OP_W-1:0] haltOperand,
    input wire logic haltPrecondMet,
    input wire logic rotZeroExec,
    input wire logic [rasm_pkg::NIB_W-1:0] accumulator,
    input wire logic stackPush,
    input wire logic stackPop,
    // core writeback
    input wire logic coreWrEn,
    input wire logic [rasm_pkg::PC_W-1:0] wbProgramCounter,
    input wire logic [rasm_pkg::DPTR_W-1:0] wbDataPointer,
    input wire logic wbStatusFlag,
    input wire logic wbCarryFlag,
    input wire logic [rasm_pkg::TIMER_W-1:0] wbTimer,
    input wire logic [rasm_pkg::PORT_W-1:0] wbPortRegLow,
    input wire logic [rasm_pkg::PORT_W-1:0] wbPortRegHigh,
    input wire logic [rasm_pkg::PORT_W-1:0] wbControlRegFirst,
    input wire logic [rasm_pkg::PORT_W-1:0] wbControlRegSecond,
    // general data registers
    input wire logic memWrEn,
    input wire logic [rasm_pkg::MEM_AW-1:0] memAddr,
    input wire logic [rasm_pkg::NIB_W-1:0] memWrData,
    output logic [rasm_pkg::NIB_W-1:0] memRdData,
    // core state
    output logic [rasm_pkg::PC_W-1:0] programCounter,
    output logic stackPointerBit,
    output logic [rasm_pkg::DPTR_W-1:0] dataPointer,
    output logic statusFlag,
    output logic carryFlag,
    output logic [rasm_pkg::TIMER_W-1:0] timer,
    output logic [rasm_pkg::PORT_W-1:0] portRegLow,
    output logic [rasm_pkg::PORT_W-1:0] portRegHigh,
    output logic [rasm_pkg::PORT_W-1:0] controlRegFirst,
    output logic [rasm_pkg::PORT_W-1:0] controlRegSecond,
    // run control
    output logic coreRun,
    output logic oscRun
);
    import rasm_pkg::*;

    localparam int MON_CW = $clog2(MON_CYC + 1);
    localparam int STAB_CW = $clog2(STAB_CYC + 1);
    localparam logic [MON_CW-1:0] MON_LAST = MON_CW'(MON_CYC - 1);
    localparam logic [STAB_CW-1:0] STAB_LAST = STAB_CW'(STAB_CYC - 1);

    rasm_phase_e phase;
    rasm_phase_e next_phase;
    logic monEnable;
    logic monReset;
    logic [MON_CW-1:0] lowCount;
    logic [STAB_CW-1:0] stabCount;
    logic relSync1;
    logic relSync2;
    logic retainFlag;
    logic standbySeen;
    logic [ST_W-1:0] status;

    // supply monitor: filter the low indication, release at once
    wire monLow = supplyLow & monEnable;
    wire monFire = monLow & (lowCount == MON_LAST);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lowCount <= '0;
        end else if (!monLow) begin
            lowCount <= '0;
        end else if (lowCount != MON_LAST) begin
            lowCount <= lowCount + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            monReset <= 1'b0;
        end else if (!monLow) begin
            monReset <= 1'b0;
        end else if (monFire) begin
            monReset <= 1'b1;
        end
    end

    // open drain: only ever pull low
    assign resetPinOut = 1'b0;
    assign resetPinOe = monReset;
    assign oscRun = resetPinIn;

    // pin and monitor combine here; faults are synchronous and act on the phase
    wire asyncRstN = nrst & resetPinIn & ~monReset;

    always_ff @(posedge clk or negedge asyncRstN) begin
        if (!asyncRstN) begin
            relSync1 <= 1'b0;
            relSync2 <= 1'b0;
        end else begin
            relSync1 <= 1'b1;
            relSync2 <= relSync1;
        end
    end

    // fault resets
    wire [2:0] haltLow = haltOperand[2:0];
    wire haltLegal = (haltLow == HALT_STOP_ALL) | (haltLow == HALT_STOP_ALT) |
        (haltLow == HALT_STOP_ONE) | (haltLow == HALT_TIMER);
    wire inRun = (phase == RASM_RUN);
    wire haltBad = inRun & haltExec & (~haltLegal | ~haltPrecondMet);
    wire rotBad = inRun & rotZeroExec & (accumulator == ACC_ZERO);
    wire stackBad = inRun & ((stackPush & stackPointerBit) | (stackPop & ~stackPointerBit));
    wire faultNow = haltBad | rotBad | stackBad;
    wire stabDone = (stabCount == STAB_LAST);
    wire releasing = (phase == RASM_RESET) & relSync2;

    always_comb begin
        next_phase = phase;
        unique case (phase)
            RASM_RESET: if (relSync2) next_phase = RASM_WAIT;
            RASM_WAIT: if (stabDone) next_phase = RASM_RUN;
            RASM_RUN: if (faultNow) next_phase = RASM_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge asyncRstN) begin
        if (!asyncRstN) begin
            phase <= RASM_RESET;
        end else begin
            phase <= next_phase;
        end
    end

    always_ff @(posedge clk or negedge asyncRstN) begin
        if (!asyncRstN) begin
            stabCount <= '0;
        end else if (phase != RASM_WAIT) begin
            stabCount <= '0;
        end else if (!stabDone) begin
            stabCount <= stabCount + 1'b1;
        end
    end

    assign coreRun = inRun;

    // reset-state core registers, reloaded every cycle of the reset phase
    wire holdDefaults = (phase == RASM_RESET);
    wire coreLoad = inRun & coreWrEn;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            programCounter <= PC_RST;
            dataPointer <= DPTR_RST;
            statusFlag <= FLAG_RST;
            carryFlag <= CARRY_RST;
            timer <= TIMER_RST;
        end else if (holdDefaults) begin
            programCounter <= PC_RST;
            dataPointer <= DPTR_RST;
            statusFlag <= FLAG_RST;
            carryFlag <= CARRY_RST;
            timer <= TIMER_RST;
        end else if (coreLoad) begin
            programCounter <= wbProgramCounter;
            dataPointer <= wbDataPointer;
            statusFlag <= wbStatusFlag;
            carryFlag <= wbCarryFlag;
            timer <= wbTimer;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            portRegLow <= PORT_LOW_RST;
            portRegHigh <= {{KEY_W{1'b0}}, PORT_HIGH_NIB_RST};
            controlRegFirst <= CTRL_FIRST_RST;
            controlRegSecond <= CTRL_SECOND_RST;
        end else if (holdDefaults) begin
            portRegLow <= PORT_LOW_RST;
            portRegHigh <= {keyInputPins, PORT_HIGH_NIB_RST};
            controlRegFirst <= CTRL_FIRST_RST;
            controlRegSecond <= CTRL_SECOND_RST;
        end else if (coreLoad) begin
            portRegLow <= wbPortRegLow;
            portRegHigh <= wbPortRegHigh;
            controlRegFirst <= wbControlRegFirst;
            controlRegSecond <= wbControlRegSecond;
        end
    end

    // one-level stack: the second push or a pop from empty is a fault
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stackPointerBit <= SP_RST;
        end else if (holdDefaults) begin
            stackPointerBit <= SP_RST;
        end else if (inRun & stackPush & ~stackPointerBit) begin
            stackPointerBit <= 1'b1;
        end else if (inRun & stackPop & stackPointerBit) begin
            stackPointerBit <= 1'b0;
        end
    end

    // data registers: writes only while running, so a reset never disturbs them
    wire memWe = inRun & memWrEn;

    rasm_data_mem #(
        .WIDTH(NIB_W),
        .DEPTH(MEM_DEPTH),
        .AW(MEM_AW)
    ) u_mem (
        .clk(clk),
        .nrst(nrst),
        .wrEn(memWe),
        .wrAddr(memAddr),
        .wrData(memWrData),
        .rdAddr(memAddr),
        .rdData(memRdData)
    );

    // contents are trustworthy only if the last reset came during standby;
    // standby is tracked while running and judged once, as the reset ends
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            standbySeen <= 1'b0;
        end else if (inRun) begin
            standbySeen <= standbyActive & ~faultNow;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            retainFlag <= 1'b0;
        end else if (releasing) begin
            retainFlag <= standbySeen;
        end
    end

    // apb decode
    wire setupPhase = psel & ~penable;
    wire accessPhase = psel & penable;
    wire hitCtrl = (paddr == ADDR_CTRL);
    wire hitStatus = (paddr == ADDR_STATUS);
    wire hitCore = (paddr == ADDR_CORE);
    wire hitPorts = (paddr == ADDR_PORTS);
    wire hitDptr = (paddr == ADDR_DPTR);
    wire hitAny = hitCtrl | hitStatus | hitCore | hitPorts | hitDptr;
    wire wrCtrl = accessPhase & pwrite & hitCtrl;
    wire wrStatus = accessPhase & pwrite & hitStatus;

    assign pready = 1'b1;
    assign pslverr = accessPhase & ~hitAny;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            monEnable <= MON_FITTED_RST;
        end else if (wrCtrl) begin
            monEnable <= pwdata[CTRL_MON_EN];
        end
    end

    // sticky causes: a new event beats a same-cycle clear
    logic [ST_W-1:0] stSet;
    logic [ST_W-1:0] stClr;
    always_comb begin
        stSet = '0;
        stSet[ST_PIN] = ~resetPinIn & ~monReset;
        stSet[ST_MON] = monReset;
        stSet[ST_HALT] = haltBad;
        stSet[ST_ROT] = rotBad;
        stSet[ST_STACK] = stackBad;
        stSet[ST_KEYS] = releasing & (keyInputPins == KEYS_ALL_HIGH);
        stClr = wrStatus ? (pwdata[ST_W-1:0] & ST_CLR_MASK) : '0;
    end

    wire [ST_W-1:0] next_status = ((status & ~stClr) | stSet) & ST_CLR_MASK;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    wire [ST_W-1:0] statusView = {retainFlag, status[ST_W-2:0]};
    wire [APB_DW-1:0] rdCtrl = {{(APB_DW-1){1'b0}}, monEnable};
    wire [APB_DW-1:0] rdStatus = {{(APB_DW-ST_PHASE_LSB-2){1'b0}}, phase, 1'b0, statusView};
    wire [APB_DW-1:0] rdCore = {6'h00, timer, 3'h0, carryFlag, statusFlag, stackPointerBit,
        programCounter};
    wire [APB_DW-1:0] rdPorts = {controlRegSecond, controlRegFirst, portRegHigh, portRegLow};
    wire [APB_DW-1:0] rdDptr = {{(APB_DW-DPTR_W){1'b0}}, dataPointer};
    wire [APB_DW-1:0] rdMux = hitCtrl ? rdCtrl : hitStatus ? rdStatus : hitCore ? rdCore :
        hitPorts ? rdPorts : hitDptr ? rdDptr : '0;

    // read data captured in the setup cycle, so zero wait states are possible
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= '0;
        end else if (setupPhase) begin
            prdata <= pwrite ? '0 : rdMux;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_release;
        phase == RASM_RESET ##1 phase == RASM_WAIT;
    endsequence

    a_pc_cleared: assert property (phase == RASM_RESET |=> programCounter == PC_RST &&
        timer == TIMER_RST && dataPointer == DPTR_RST && !stackPointerBit)
        else $error("core state not cleared by reset");
    a_port_defaults: assert property (phase == RASM_RESET |=> portRegLow == PORT_LOW_RST &&
        controlRegFirst == CTRL_FIRST_RST && controlRegSecond == CTRL_SECOND_RST)
        else $error("port or control defaults wrong after reset");
    a_key_nibble: assert property (phase == RASM_RESET |=>
        portRegHigh == {$past(keyInputPins), PORT_HIGH_NIB_RST})
        else $error("high port register does not show key pins");
    a_mem_frozen: assert property (memWe |-> coreRun && phase == RASM_RUN)
        else $error("data register written outside run");
    a_retain_hold: assert property (phase != RASM_RESET |=> $stable(retainFlag))
        else $error("retained flag changed outside a reset");
    a_halt_fault: assert property (inRun && haltExec && !haltLegal |=> phase == RASM_RESET)
        else $error("illegal standby operand did not reset");
    a_rot_fault: assert property (inRun && rotZeroExec && accumulator == ACC_ZERO
        |=> phase == RASM_RESET)
        else $error("rotate with zero accumulator did not reset");
    a_stack_fault: assert property (inRun && stackPush && stackPointerBit
        |=> phase == RASM_RESET)
        else $error("stack overflow did not reset");
    a_pin_or: assert property (!resetPinIn |=> phase == RASM_RESET && !coreRun)
        else $error("reset pin low but core not held");
    a_pin_drive: assert property (monReset |-> resetPinOe && !resetPinOut)
        else $error("reset pin not pulled low by monitor");
    a_mon_assert: assert property (monFire |=> monReset)
        else $error("monitor did not assert after filter time");
    a_mon_release: assert property (!supplyLow |=> !monReset)
        else $error("monitor reset not released");
    a_mon_filter: assert property ($rose(monReset) |-> $past(lowCount) == MON_LAST)
        else $error("monitor asserted before filter time");
    a_stab_wait: assert property (s_release |-> (phase == RASM_WAIT) [*8])
        else $error("settling wait too short");
    a_stab_end: assert property (phase == RASM_RUN && $past(phase) == RASM_WAIT
        |-> $past(stabCount) == STAB_LAST)
        else $error("settling wait length wrong");
endmodule : rasm_reset_monitor

// [shared/rasm_pkg.sv]
// constants, register map and phase type of the reset and supply monitor
package rasm_pkg;
    // widths
    localparam int PC_W = 10;
    localparam int TIMER_W = 10;
    localparam int DPTR_W = 8;
    localparam int PORT_W = 8;
    localparam int KEY_W = 4;
    localparam int NIB_W = 4;
    localparam int HALT_OP_W = 4;
    localparam int MEM_AW = 4;
    localparam int MEM_DEPTH = 16;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // reset values
    localparam logic [PC_W-1:0] PC_RST = 10'h000;
    localparam logic SP_RST = 1'b0;
    localparam logic [DPTR_W-1:0] DPTR_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam logic CARRY_RST = 1'b0;
    localparam logic [TIMER_W-1:0] TIMER_RST = 10'h000;
    localparam logic [PORT_W-1:0] PORT_LOW_RST = 8'hff;
    localparam logic [NIB_W-1:0] PORT_HIGH_NIB_RST = 4'hf;
    localparam logic [PORT_W-1:0] CTRL_FIRST_RST = 8'h03;
    localparam logic [PORT_W-1:0] CTRL_SECOND_RST = 8'h26;
    localparam logic [NIB_W-1:0] ACC_ZERO = 4'h0;
    localparam logic [KEY_W-1:0] KEYS_ALL_HIGH = 4'hf;
    localparam logic MON_FITTED_RST = 1'b1;

    // legal low three operand bits of the standby instruction
    localparam logic [2:0] HALT_STOP_ALL = 3'h0;
    localparam logic [2:0] HALT_STOP_ALT = 3'h3;
    localparam logic [2:0] HALT_STOP_ONE = 3'h6;
    localparam logic [2:0] HALT_TIMER = 3'h5;

    // timing
    localparam int CLK_KHZ = 25000;
    localparam int MON_FILTER_MS = 1;
    localparam int MON_FILTER_CYC = MON_FILTER_MS * CLK_KHZ;
    localparam int STAB_MIN_FX = 60;
    localparam int STAB_MAX_FX = 116;

    // register map
    localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_CORE = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_PORTS = 8'h0c;
    localparam logic [APB_AW-1:0] ADDR_DPTR = 8'h10;

    // control fields
    localparam int CTRL_MON_EN = 0;
    // status fields
    localparam int ST_W = 7;
    localparam int ST_PIN = 0;
    localparam int ST_MON = 1;
    localparam int ST_HALT = 2;
    localparam int ST_ROT = 3;
    localparam int ST_STACK = 4;
    localparam int ST_KEYS = 5;
    localparam int ST_RETAIN = 6;
    localparam logic [ST_W-1:0] ST_CLR_MASK = 7'h3f;
    localparam int ST_PHASE_LSB = 8;

    typedef enum logic [1:0] {RASM_RESET, RASM_WAIT, RASM_RUN} rasm_phase_e;
endpackage : rasm_pkg

// [rtl/rasm_data_mem.sv]
// general data register file kept across standby resets
`timescale 1ns/1ps
module rasm_data_mem #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // read port
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    // no reset on the array: contents must survive the chip reset
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData <= '0;
        end else begin
            rdData <= store[rdAddr];
        end
    end
endmodule : rasm_data_mem

// [tb/rasm_ext_reset_model.sv]
// external reset circuit and key matrix seen from the device pins
`timescale 1ns/1ps
module rasm_ext_reset_model (
    // bench requests
    input wire logic holdReset,
    input wire logic [rasm_pkg::KEY_W-1:0] keyLevels,
    // device pins
    input wire logic resetPinOe,
    input wire logic resetPinOut,
    output logic resetPinIn,
    output logic [rasm_pkg::KEY_W-1:0] keyInputPins
);
    // open-drain line with pull-up: low while either party pulls
    assign resetPinIn = (holdReset || (resetPinOe && !resetPinOut)) ? 1'b0 : 1'b1;
    // key 0 held low while the line is low; a release comes with the line high and sees keyLevels
    assign keyInputPins = resetPinIn ? keyLevels : (keyLevels & 4'he);
endmodule : rasm_ext_reset_model

// [tb/rasm_reset_monitor_tb.sv]
// self-checking bench for the reset sequencer and supply monitor
`timescale 1ns/1ps
module rasm_reset_monitor_tb;
    import rasm_pkg::*;
    localparam int MON_T = 20;
    localparam int STAB_T = 12;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 8'h00;
    logic [APB_DW-1:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, resetPinIn, resetPinOut, resetPinOe, coreRun, oscRun;
    logic holdReset = 1'b0, supplyLow = 1'b0, standbyActive = 1'b0, haltExec = 1'b0;
    logic haltPrecondMet = 1'b0, rotZeroExec = 1'b0, stackPush = 1'b0, stackPop = 1'b0;
    logic coreWrEn = 1'b0, memWrEn = 1'b0, stackPointerBit, statusFlag, carryFlag;
    logic [KEY_W-1:0] keyLevels = 4'h6, keyInputPins;
    logic [HALT_OP_W-1:0] haltOperand = 4'h0;
    logic [NIB_W-1:0] accumulator = 4'h3, memWrData = 4'h0, memRdData;
    logic [MEM_AW-1:0] memAddr = 4'h0;
    logic [PC_W-1:0] wbProgramCounter = 10'h2a5, programCounter;
    logic [TIMER_W-1:0] wbTimer = 10'h155, timer;
    logic [DPTR_W-1:0] wbDataPointer = 8'h5a, dataPointer;
    logic wbStatusFlag = 1'b1, wbCarryFlag = 1'b1;
    logic [PORT_W-1:0] wbPortRegLow = 8'h12, wbPortRegHigh = 8'h34, portRegLow, portRegHigh;
    logic [PORT_W-1:0] wbControlRegFirst = 8'h56, wbControlRegSecond = 8'h78;
    logic [PORT_W-1:0] controlRegFirst, controlRegSecond;
    int mismatches = 0, cmp_count = 0, cycles = 0;

    rasm_ext_reset_model ext_u (.holdReset(holdReset), .keyLevels(keyLevels),
        .resetPinOe(resetPinOe), .resetPinOut(resetPinOut), .resetPinIn(resetPinIn),
        .keyInputPins(keyInputPins));
    rasm_reset_monitor #(.MON_CYC(MON_T), .STAB_CYC(STAB_T)) dut_u (.clk(clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .resetPinIn(resetPinIn),
        .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .supplyLow(supplyLow),
        .keyInputPins(keyInputPins), .standbyActive(standbyActive), .haltExec(haltExec),
        .haltOperand(haltOperand), .haltPrecondMet(haltPrecondMet), .rotZeroExec(rotZeroExec),
        .accumulator(accumulator), .stackPush(stackPush), .stackPop(stackPop),
        .coreWrEn(coreWrEn), .wbProgramCounter(wbProgramCounter), .wbDataPointer(wbDataPointer),
        .wbStatusFlag(wbStatusFlag), .wbCarryFlag(wbCarryFlag), .wbTimer(wbTimer),
        .wbPortRegLow(wbPortRegLow), .wbPortRegHigh(wbPortRegHigh),
        .wbControlRegFirst(wbControlRegFirst), .wbControlRegSecond(wbControlRegSecond),
        .memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
        .programCounter(programCounter), .stackPointerBit(stackPointerBit),
        .dataPointer(dataPointer), .statusFlag(statusFlag), .carryFlag(carryFlag),
        .timer(timer), .portRegLow(portRegLow), .portRegHigh(portRegHigh),
        .controlRegFirst(controlRegFirst), .controlRegSecond(controlRegSecond),
        .coreRun(coreRun), .oscRun(oscRun));

    always #20 clk = ~clk;

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // tests take about three hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] wd,
                       output logic [APB_DW-1:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic waitRun(output int n);
        n = 0;
        while (coreRun !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        check(32'(coreRun), 32'h1, "run reached");
    endtask : waitRun

    // read the status word, check one cause bit, then clear all causes
    task automatic checkCause(input int bitIdx, input string msg);
        logic [31:0] rd;
        logic err;
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        check(32'(rd[bitIdx]), 32'h1, msg);
        apb(1'b1, ADDR_STATUS, 32'(ST_CLR_MASK), rd, err);
    endtask : checkCause

    task automatic test_apb();
        logic [31:0] rd;
        logic err;
        apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
        check(rd, 32'h1, "monitor enabled at reset");
        apb(1'b0, 8'h20, 32'h0, rd, err);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        $display("test apb done");
    endtask : test_apb

    task automatic test_pin_reset();
        int n;
        @(posedge clk);
        coreWrEn <= 1'b1;
        @(posedge clk);
        coreWrEn <= 1'b0;
        @(posedge clk);
        check(32'(programCounter), 32'h2a5, "core load");
        holdReset <= 1'b1;
        repeat (5) @(posedge clk);
        check(32'({oscRun, coreRun}), 32'h0, "oscillator and run while pin low");
        holdReset <= 1'b0;
        waitRun(n);
        // exact wait figure is the shortened parameter plus the synchroniser
        check(32'(n >= STAB_T && n <= STAB_T + 6), 32'h1, "settling wait");
        check(32'({programCounter, stackPointerBit, dataPointer, statusFlag, carryFlag}),
              32'({PC_RST, SP_RST, DPTR_RST, FLAG_RST, CARRY_RST}), "core defaults");
        check(32'(timer), 32'(TIMER_RST), "timer default");
        check(32'({portRegLow, controlRegFirst, controlRegSecond}),
              32'({PORT_LOW_RST, CTRL_FIRST_RST, CTRL_SECOND_RST}), "port defaults");
        check(32'(portRegHigh), 32'({keyLevels, PORT_HIGH_NIB_RST}), "high port");
        checkCause(ST_PIN, "pin cause");
        $display("test pin reset done");
    endtask : test_pin_reset

    // kinds 4, 5 and 6 are legal and must not reset; 6 then 7 overflow the stack
    task automatic test_faults();
        int n;
        logic hit;
        for (int k = 0; k < 8; k++) begin
            hit = (k < 4 || k == 7);
            @(posedge clk);
            haltExec <= (k == 0 || k == 1 || k == 5);
            haltOperand <= (k == 0) ? 4'h1 : (k == 1) ? {1'b0, HALT_STOP_ALL} : {1'b0, HALT_TIMER};
            haltPrecondMet <= (k != 1);
            rotZeroExec <= (k == 2 || k == 4);
            accumulator <= (k == 2) ? ACC_ZERO : 4'h3;
            stackPop <= (k == 3);
            stackPush <= (k >= 6);
            @(posedge clk);
            haltExec <= 1'b0;
            rotZeroExec <= 1'b0;
            stackPop <= 1'b0;
            stackPush <= 1'b0;
            repeat (3) @(posedge clk);
            check(32'(coreRun), 32'(!hit), "fault reset");
            if (hit) begin
                waitRun(n);
                checkCause((k < 2) ? ST_HALT : (k == 2) ? ST_ROT : ST_STACK, "fault cause");
            end
        end
        $display("test faults done");
    endtask : test_faults

    task automatic test_monitor();
        int n;
        logic [31:0] rd;
        logic err;
        @(posedge clk);
        memWrEn <= 1'b1;
        memAddr <= 4'h5;
        memWrData <= 4'ha;
        @(posedge clk);
        memWrEn <= 1'b0;
        supplyLow <= 1'b1;
        repeat (MON_T / 2) @(posedge clk);
        supplyLow <= 1'b0;
        repeat (4) @(posedge clk);
        check(32'({coreRun, resetPinOe}), 32'h2, "short dip ignored");
        apb(1'b1, ADDR_CTRL, 32'h0, rd, err);
        supplyLow <= 1'b1;
        repeat (MON_T * 2) @(posedge clk);
        check(32'(coreRun), 32'h1, "monitor not fitted");
        supplyLow <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h1, rd, err);
        standbyActive <= 1'b1;
        supplyLow <= 1'b1;
        n = 0;
        while (resetPinOe !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        check(32'(n >= MON_T - 1 && n <= MON_T + 4), 32'h1, "filter delay");
        check(32'({resetPinIn, coreRun}), 32'h0, "pin pulled low");
        supplyLow <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'(resetPinOe), 32'h0, "monitor release");
        standbyActive <= 1'b0;
        waitRun(n);
        repeat (2) @(posedge clk);
        check(32'(memRdData), 32'ha, "data kept over standby reset");
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        check(32'({rd[ST_RETAIN], rd[ST_MON]}), 32'h3, "retained and monitor cause");
        $display("test monitor done");
    endtask : test_monitor

    initial begin
        int n;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        waitRun(n);
        test_apb();
        test_pin_reset();
        test_faults();
        test_monitor();
        stop_test();
    end
endmodule : rasm_reset_monitor_tb
